// ==== core/fault_pkg.sv ====
// Package: fault codes, timing constants and load levels
package fault_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned STALL_MS = 3000;
	localparam int unsigned AIR_MS = 4000;
	localparam int unsigned OVL4_MS = 30000;
	localparam int unsigned OVL5_MS = 10000;
	localparam int unsigned OVL6_MS = 5000;
	localparam int unsigned BLINK_MS = 250;
	localparam int unsigned STALL_CYC = STALL_MS * (CLK_HZ / 1000);
	localparam int unsigned AIR_CYC = AIR_MS * (CLK_HZ / 1000);
	localparam int unsigned OVL4_CYC = OVL4_MS * (CLK_HZ / 1000);
	localparam int unsigned OVL5_CYC = OVL5_MS * (CLK_HZ / 1000);
	localparam int unsigned OVL6_CYC = OVL6_MS * (CLK_HZ / 1000);
	localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
	localparam logic [2:0] LOAD_WARN = 3'h4;
	localparam logic [2:0] LOAD_MID = 3'h5;
	localparam logic [2:0] LOAD_HIGH = 3'h6;
	// Two display characters, ASCII
	localparam logic [15:0] CODE_NONE = 16'h2020;
	localparam logic [15:0] CODE_E1 = 16'h4531;
	localparam logic [15:0] CODE_E2 = 16'h4532;
	localparam logic [15:0] CODE_E3 = 16'h4533;
	localparam logic [15:0] CODE_E4 = 16'h4534;
	localparam logic [15:0] CODE_E5 = 16'h4535;
	localparam logic [15:0] CODE_E6 = 16'h4536;
	localparam logic [15:0] CODE_E7 = 16'h4537;
	localparam logic [15:0] CODE_TORQUE = 16'h4538;
	localparam logic [15:0] CODE_E9 = 16'h4539;
	localparam logic [15:0] CODE_ILLEGAL = 16'h4541;
	localparam logic [15:0] CODE_EL = 16'h454c;
	localparam logic [15:0] CODE_EH = 16'h4548;
	localparam logic [15:0] CODE_ESTOP = 16'h4545;
	localparam logic [15:0] CODE_EC = 16'h4543;
	localparam logic [15:0] CODE_WARN = 16'h4133;
	localparam logic [4:0] IRQ_FAULT = 5'h01;
	localparam int unsigned IRQ_FAULT_BIT = 0;
	localparam int unsigned IRQ_WARN_BIT = 1;
	localparam int unsigned IRQ_CLEAR_BIT = 2;
	localparam int unsigned IRQ_W = 3;
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_MASK = 4'h1;
	localparam logic [3:0] REG_CTRL = 4'h2;
	localparam logic [3:0] REG_CODE = 4'h3;
	localparam logic [3:0] REG_TIMER = 4'h4;
	localparam int unsigned CTRL_NC_BIT = 0;
	localparam int unsigned CTRL_SEL_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;
endpackage

// ==== core/hold_timer.sv ====
// Module: counts cycles while a condition holds, flags when limit passed
`timescale 1ns/1ps
module hold_timer #(
	parameter int unsigned W = 32
)(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic active,
	input wire logic [W-1:0] limit,
	output logic expired,
	output logic [W-1:0] count
);
	logic [W-1:0] count_ff;
	always_ff @(posedge ref_clk)
	begin
		if (rst || !active)
			count_ff <= '0;
		else if (count_ff <= limit)
			count_ff <= count_ff + 1'b1;
	end
	// Strictly longer than the limit
	assign expired = active && (count_ff > limit);
	assign count = count_ff;
endmodule

// ==== core/release_seq.sv ====
// Module: open-closed-open detector on the fault release contact
`timescale 1ns/1ps
module release_seq (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic release_closed,
	output logic done
);
	typedef enum {WAIT_OPEN, WAIT_CLOSE, WAIT_REOPEN} seq_type;
	seq_type st_ff;
	seq_type nxt_st;
	always_comb
	begin
		nxt_st = st_ff;
		done = 1'b0;
		case (st_ff)
			WAIT_OPEN: if (!release_closed) nxt_st = WAIT_CLOSE;
			WAIT_CLOSE: if (release_closed) nxt_st = WAIT_REOPEN;
			WAIT_REOPEN:
				if (!release_closed)
				begin
					done = 1'b1;
					nxt_st = WAIT_CLOSE;
				end
			default: nxt_st = WAIT_OPEN;
		endcase
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			st_ff <= WAIT_OPEN;
		else
			st_ff <= nxt_st;
	end
endmodule

// ==== core/fault_latch_overload_monitor.sv ====
// Module: fault latch, reset paths and torque overload timing
`timescale 1ns/1ps
//
// Function
// - Manual mode: panel button clears fault
// - Auto mode: open-closed-open release clears fault
// - Report E1..E5 detector faults as codes
// - Stall over three seconds raises E6
// - Low air: four seconds rotating, or start
// - Auto: command closed at power on faults
// - Auto: release without command open faults
// - Emergency stop open raises its code
// - Comm loss fault only with switch unit
// - Codes for unknown motor, overspeed, memory
// - Internal damage faults never clear
// - Four segments: blink lamp, warn code, contact
// - Overload limits 30s, 10s, 5s by level
// - Overload expiry stops motor, raises torque code
// - Any fault: stop, lamp, code, output
// - Setting picks open or closed fault contact
module fault_latch_overload_monitor #(
	parameter int unsigned STALL_CYC = fault_pkg::STALL_CYC,
	parameter int unsigned AIR_CYC = fault_pkg::AIR_CYC,
	parameter int unsigned OVL4_CYC = fault_pkg::OVL4_CYC,
	parameter int unsigned OVL5_CYC = fault_pkg::OVL5_CYC,
	parameter int unsigned OVL6_CYC = fault_pkg::OVL6_CYC,
	parameter int unsigned BLINK_CYC = fault_pkg::BLINK_CYC
)(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic auto_mode,
	input wire logic panel_reset_btn,
	input wire logic release_closed,
	input wire logic rotate_cmd,
	input wire logic control_cmd,
	input wire logic start_req,
	input wire logic rotating,
	input wire logic over_current,
	input wire logic over_voltage,
	input wire logic sensor_fail,
	input wire logic ctrl_overheat,
	input wire logic brake_fail,
	input wire logic stalled,
	input wire logic air_low,
	input wire logic estop_closed,
	input wire logic remote_spindle_switch_unit,
	input wire logic comm_lost,
	input wire logic motor_unknown,
	input wire logic over_speed,
	input wire logic memory_fail,
	input wire logic internal_damage,
	input wire logic [2:0] load_level,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic motor_stop,
	output logic fault_lamp,
	output logic warn_lamp,
	output logic fault_contact,
	output logic warn_contact,
	output logic [15:0] display_code,
	output logic irq
);
	logic fault_ff;
	logic permanent_ff;
	logic [15:0] code_ff;
	logic [1:0] ctrl_ff;
	logic [fault_pkg::IRQ_W-1:0] status_ff;
	logic [fault_pkg::IRQ_W-1:0] mask_ff;
	logic [31:0] rdata_ff;
	logic powered_ff;
	logic btn_prev_ff;
	logic cmd_opened_ff;
	logic [31:0] blink_cnt_ff;
	logic blink_ff;
	logic [15:0] nxt_code;
	logic cause;
	logic stall_exp;
	logic air_exp;
	logic ovl_exp;
	logic overload;
	logic [31:0] ovl_limit;
	logic [31:0] ovl_count;
	logic release_done;
	logic clear_req;
	logic illegal_release;
	logic power_on_cmd;
	logic btn_press;

	hold_timer #(.W(32)) stall_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.active(stalled),
		.limit(32'(STALL_CYC)),
		.expired(stall_exp),
		.count()
	);
	hold_timer #(.W(32)) air_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.active(air_low && rotating),
		.limit(32'(AIR_CYC)),
		.expired(air_exp),
		.count()
	);
	// Level change only swaps the limit, so a rising load cannot reset it
	assign overload = load_level >= fault_pkg::LOAD_WARN;
	always_comb
	begin
		if (load_level >= fault_pkg::LOAD_HIGH)
			ovl_limit = 32'(OVL6_CYC);
		else if (load_level == fault_pkg::LOAD_MID)
			ovl_limit = 32'(OVL5_CYC);
		else
			ovl_limit = 32'(OVL4_CYC);
	end
	hold_timer #(.W(32)) ovl_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.active(overload),
		.limit(ovl_limit),
		.expired(ovl_exp),
		.count(ovl_count)
	);

	release_seq rel (
		.ref_clk(ref_clk),
		.rst(rst),
		.release_closed(release_closed),
		.done(release_done)
	);

	// Power-on sample of the control command, taken after reset release
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			powered_ff <= 1'b0;
		else
			powered_ff <= 1'b1;
	end
	assign power_on_cmd = !powered_ff && !rst && auto_mode && control_cmd;

	// Command must be seen open while faulted before release is legal
	always_ff @(posedge ref_clk)
	begin
		if (rst || !fault_ff)
			cmd_opened_ff <= 1'b0;
		else if (!control_cmd)
			cmd_opened_ff <= 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			btn_prev_ff <= 1'b0;
		else
			btn_prev_ff <= panel_reset_btn;
	end
	assign btn_press = panel_reset_btn && !btn_prev_ff;

	// Priority order: most severe cause wins the display
	always_comb
	begin
		nxt_code = fault_pkg::CODE_NONE;
		if (memory_fail)
			nxt_code = fault_pkg::CODE_EC;
		else if (!estop_closed)
			nxt_code = fault_pkg::CODE_ESTOP;
		else if (over_current)
			nxt_code = fault_pkg::CODE_E1;
		else if (over_voltage)
			nxt_code = fault_pkg::CODE_E2;
		else if (sensor_fail)
			nxt_code = fault_pkg::CODE_E3;
		else if (ctrl_overheat)
			nxt_code = fault_pkg::CODE_E4;
		else if (brake_fail)
			nxt_code = fault_pkg::CODE_E5;
		else if (stall_exp)
			nxt_code = fault_pkg::CODE_E6;
		else if (air_exp || (air_low && start_req))
			nxt_code = fault_pkg::CODE_E7;
		else if (ovl_exp)
			nxt_code = fault_pkg::CODE_TORQUE;
		else if (remote_spindle_switch_unit && comm_lost)
			nxt_code = fault_pkg::CODE_E9;
		else if (power_on_cmd)
			nxt_code = fault_pkg::CODE_ILLEGAL;
		else if (motor_unknown)
			nxt_code = fault_pkg::CODE_EL;
		else if (over_speed)
			nxt_code = fault_pkg::CODE_EH;
	end
	assign cause = nxt_code != fault_pkg::CODE_NONE;

	assign illegal_release = auto_mode && release_done && !cmd_opened_ff;
	assign clear_req = auto_mode ? release_done : btn_press;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			fault_ff <= 1'b0;
			code_ff <= fault_pkg::CODE_NONE;
		end
		else if (!fault_ff && cause)
		begin
			fault_ff <= 1'b1;
			code_ff <= nxt_code;
		end
		else if (fault_ff && illegal_release)
			code_ff <= fault_pkg::CODE_ILLEGAL;
		else if (fault_ff && clear_req && !cause && !permanent_ff)
		begin
			fault_ff <= 1'b0;
			code_ff <= fault_pkg::CODE_NONE;
		end
	end

	// Internal damage is sticky until power is cycled
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			permanent_ff <= 1'b0;
		else if (internal_damage)
			permanent_ff <= 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst || !overload)
		begin
			blink_cnt_ff <= 32'h0;
			blink_ff <= 1'b0;
		end
		else if (blink_cnt_ff >= 32'(BLINK_CYC - 1))
		begin
			blink_cnt_ff <= 32'h0;
			blink_ff <= !blink_ff;
		end
		else
			blink_cnt_ff <= blink_cnt_ff + 32'h1;
	end

	logic faulted;
	assign faulted = fault_ff || permanent_ff;
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			motor_stop <= 1'b0;
			fault_lamp <= 1'b0;
			fault_contact <= 1'b0;
			warn_lamp <= 1'b0;
			warn_contact <= 1'b0;
			display_code <= fault_pkg::CODE_NONE;
		end
		else
		begin
			motor_stop <= faulted;
			fault_lamp <= faulted;
			fault_contact <= faulted ^ ctrl_ff[fault_pkg::CTRL_NC_BIT];
			warn_lamp <= overload && !blink_ff;
			warn_contact <= overload;
			if (faulted)
				display_code <= permanent_ff && !fault_ff ?
					fault_pkg::CODE_E4 : code_ff;
			else if (overload)
				display_code <= fault_pkg::CODE_WARN;
			else
				display_code <= fault_pkg::CODE_NONE;
		end
	end

	// Register port: status is write-one-to-clear, set wins
	logic [fault_pkg::IRQ_W-1:0] events;
	assign events = {fault_ff && clear_req && !cause && !permanent_ff
		&& !illegal_release, overload && !warn_contact, !fault_ff && cause};
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			status_ff <= '0;
		else if (reg_wr && reg_addr == fault_pkg::REG_STATUS)
			status_ff <= (status_ff & ~reg_wdata[fault_pkg::IRQ_W-1:0])
				| events;
		else
			status_ff <= status_ff | events;
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			mask_ff <= fault_pkg::MASK_RESET;
		else if (reg_wr && reg_addr == fault_pkg::REG_MASK)
			mask_ff <= reg_wdata[fault_pkg::IRQ_W-1:0];
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			ctrl_ff <= fault_pkg::CTRL_RESET;
		else if (reg_wr && reg_addr == fault_pkg::REG_CTRL)
			ctrl_ff <= reg_wdata[1:0];
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			rdata_ff <= 32'h0;
		else if (reg_rd)
			case (reg_addr)
				fault_pkg::REG_STATUS: rdata_ff <= {29'h0, status_ff};
				fault_pkg::REG_MASK: rdata_ff <= {29'h0, mask_ff};
				fault_pkg::REG_CTRL: rdata_ff <= {30'h0, ctrl_ff};
				fault_pkg::REG_CODE:
					rdata_ff <= {14'h0, permanent_ff, fault_ff, code_ff};
				fault_pkg::REG_TIMER: rdata_ff <= ovl_count;
				default: rdata_ff <= 32'h0;
			endcase
		else
			rdata_ff <= 32'h0;
	end
	assign reg_rdata = rdata_ff;
	assign irq = |(status_ff & mask_ff);

	chk_fault_drives_outputs: assert property (@(posedge ref_clk)
		disable iff (rst) fault_ff |=> motor_stop && fault_lamp)
		else $error("fault did not stop motor");
	chk_contact_polarity: assert property (@(posedge ref_clk)
		disable iff (rst) 1'b1 |=> fault_contact ==
		($past(faulted) ^ $past(ctrl_ff[fault_pkg::CTRL_NC_BIT])))
		else $error("fault contact polarity wrong");
	chk_warn_contact: assert property (@(posedge ref_clk)
		disable iff (rst) overload |=> warn_contact)
		else $error("warning contact not closed");
	chk_warn_drop: assert property (@(posedge ref_clk)
		disable iff (rst) !overload |=> !warn_contact && !warn_lamp)
		else $error("warning not withdrawn");
	chk_permanent_hold: assert property (@(posedge ref_clk)
		disable iff (rst) permanent_ff |=> ##1 fault_contact !=
		ctrl_ff[fault_pkg::CTRL_NC_BIT] || $changed(ctrl_ff))
		else $error("damage fault was cleared");
	chk_hold_no_reset: assert property (@(posedge ref_clk)
		disable iff (rst) fault_ff && !clear_req |=> fault_ff)
		else $error("fault dropped without reset");
	chk_manual_clear: assert property (@(posedge ref_clk)
		disable iff (rst) fault_ff && !auto_mode && btn_press && !cause
		&& !permanent_ff |=> !fault_ff)
		else $error("button did not clear fault");
	chk_auto_clear: assert property (@(posedge ref_clk)
		disable iff (rst) fault_ff && auto_mode && release_done && !cause
		&& !permanent_ff && cmd_opened_ff |=> !fault_ff)
		else $error("release did not clear fault");
	chk_overload_e8: assert property (@(posedge ref_clk)
		disable iff (rst) !fault_ff && ovl_exp && nxt_code ==
		fault_pkg::CODE_TORQUE |=> code_ff == fault_pkg::CODE_TORQUE)
		else $error("torque code not latched");
	chk_estop_code: assert property (@(posedge ref_clk)
		disable iff (rst) !fault_ff && !estop_closed && !memory_fail
		|=> code_ff == fault_pkg::CODE_ESTOP)
		else $error("estop code not latched");
endmodule

// ==== sim/machine_host.sv ====
// Host machine model driving the command and release contacts
`timescale 1ns/1ps
module machine_host (
	input wire logic ref_clk,
	output logic release_closed,
	output logic control_cmd,
	output logic rotate_cmd
);
	initial
	begin
		release_closed = 1'b0;
		control_cmd = 1'b0;
		rotate_cmd = 1'b0;
	end
	task automatic set_cmd(input logic v);
		@(posedge ref_clk);
		control_cmd <= v;
		rotate_cmd <= v;
	endtask
	// Each phase held three cycles so a slow detector still sees it
	task automatic release_fault();
		repeat (3) @(posedge ref_clk);
		release_closed <= 1'b1;
		repeat (3) @(posedge ref_clk);
		release_closed <= 1'b0;
		repeat (3) @(posedge ref_clk);
		if (rotate_cmd)
		begin
			rotate_cmd <= 1'b0;
		end
	endtask
endmodule

// ==== sim/fault_latch_overload_monitor_tb.sv ====
// Testbench for the fault latch and overload monitor
`timescale 1ns/1ps
module fault_latch_overload_monitor_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic auto_mode = 1'b1;
	logic btn = 1'b0;
	logic start_req = 1'b0;
	logic rotating = 1'b0;
	logic stalled = 1'b0;
	logic air_low = 1'b0;
	logic unit = 1'b1;
	logic dmg = 1'b0;
	logic [9:0] det = 10'h0;
	logic [2:0] load = 3'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic motor_stop, fault_lamp, warn_lamp, fault_contact, warn_contact;
	logic [15:0] display_code;
	logic irq, release_closed, control_cmd, rotate_cmd;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	logic [15:0] codes [10] = '{fault_pkg::CODE_E1, fault_pkg::CODE_E2,
		fault_pkg::CODE_E3, fault_pkg::CODE_E4, fault_pkg::CODE_E5,
		fault_pkg::CODE_EL, fault_pkg::CODE_EH, fault_pkg::CODE_EC,
		fault_pkg::CODE_ESTOP, fault_pkg::CODE_E9};
	logic [2:0] lv [3] = '{3'h4, 3'h5, 3'h6};
	int lim [3] = '{50, 40, 30};

	always #50 ref_clk = ~ref_clk;

	machine_host machine_host_i (
		.ref_clk(ref_clk),
		.release_closed(release_closed),
		.control_cmd(control_cmd),
		.rotate_cmd(rotate_cmd)
	);

	// Short counts keep every timed fault within a few dozen cycles
	fault_latch_overload_monitor #(
		.STALL_CYC(20),
		.AIR_CYC(30),
		.OVL4_CYC(50),
		.OVL5_CYC(40),
		.OVL6_CYC(30)
	) fault_latch_overload_monitor_i (
		.ref_clk(ref_clk),
		.rst(rst),
		.auto_mode(auto_mode),
		.panel_reset_btn(btn),
		.release_closed(release_closed),
		.rotate_cmd(rotate_cmd),
		.control_cmd(control_cmd),
		.start_req(start_req),
		.rotating(rotating),
		.over_current(det[0]),
		.over_voltage(det[1]),
		.sensor_fail(det[2]),
		.ctrl_overheat(det[3]),
		.brake_fail(det[4]),
		.stalled(stalled),
		.air_low(air_low),
		.estop_closed(~det[8]),
		.remote_spindle_switch_unit(unit),
		.comm_lost(det[9]),
		.motor_unknown(det[5]),
		.over_speed(det[6]),
		.memory_fail(det[7]),
		.internal_damage(dmg),
		.load_level(load),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.motor_stop(motor_stop),
		.fault_lamp(fault_lamp),
		.warn_lamp(warn_lamp),
		.fault_contact(fault_contact),
		.warn_contact(warn_contact),
		.display_code(display_code),
		.irq(irq)
	);

	task automatic end_of_test();
		if (n_mismatch == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input string n, input logic [31:0] g, e);
		total_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Sample one step after the edge so its updates have landed
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic out(input logic [15:0] c, input logic f);
		check("fault outputs", {13'h0, motor_stop, fault_lamp, fault_contact,
			display_code}, {13'h0, f, f, f, c});
	endtask

	task automatic warn(input logic w);
		check("warn outputs", {15'h0, warn_contact, display_code},
			{15'h0, w, w ? fault_pkg::CODE_WARN : fault_pkg::CODE_NONE});
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		check("read data", reg_rdata, e);
	endtask

	task automatic press();
		@(posedge ref_clk);
		btn <= 1'b1;
		wt(2);
		btn <= 1'b0;
		wt(3);
	endtask

	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_mismatch++;
			end_of_test();
		end
	end

	initial
	begin
		machine_host_i.set_cmd(1'b1);
		wt(5);
		rst <= 1'b0;
		wt(4);
		out(fault_pkg::CODE_ILLEGAL, 1'b1);
		machine_host_i.release_fault();
		wt(3);
		out(fault_pkg::CODE_ILLEGAL, 1'b1);
		machine_host_i.set_cmd(1'b0);
		machine_host_i.release_fault();
		wt(3);
		out(fault_pkg::CODE_NONE, 1'b0);
		auto_mode <= 1'b0;
		wr(fault_pkg::REG_STATUS, 32'h7);
		wr(fault_pkg::REG_MASK, 32'h1);
		for (int k = 0; k < 10; k++)
		begin
			det <= 10'h1 << k;
			wt(4);
			out(codes[k], 1'b1);
			press();
			out(codes[k], 1'b1);
			det <= 10'h0;
			press();
			out(fault_pkg::CODE_NONE, 1'b0);
		end
		check("irq", {31'h0, irq}, 32'h1);
		rd(fault_pkg::REG_STATUS, 32'h5);
		wr(fault_pkg::REG_STATUS, 32'h1);
		wt(2);
		check("irq", {31'h0, irq}, 32'h0);
		rd(fault_pkg::REG_STATUS, 32'h4);
		rd(4'hf, 32'h0);
		unit <= 1'b0;
		det <= 10'h200;
		wt(6);
		out(fault_pkg::CODE_NONE, 1'b0);
		unit <= 1'b1;
		det <= 10'h0;
		stalled <= 1'b1;
		wt(10);
		out(fault_pkg::CODE_NONE, 1'b0);
		wt(20);
		out(fault_pkg::CODE_E6, 1'b1);
		stalled <= 1'b0;
		press();
		air_low <= 1'b1;
		start_req <= 1'b1;
		wt(4);
		out(fault_pkg::CODE_E7, 1'b1);
		start_req <= 1'b0;
		air_low <= 1'b0;
		press();
		air_low <= 1'b1;
		rotating <= 1'b1;
		wt(20);
		out(fault_pkg::CODE_NONE, 1'b0);
		wt(15);
		out(fault_pkg::CODE_E7, 1'b1);
		air_low <= 1'b0;
		rotating <= 1'b0;
		press();
		load <= 3'h4;
		wt(40);
		warn(1'b1);
		check("warn lamp", {31'h0, warn_lamp}, 32'h1);
		rd(fault_pkg::REG_TIMER, 32'h29);
		load <= 3'h3;
		wt(3);
		warn(1'b0);
		load <= 3'h4;
		wt(40);
		out(fault_pkg::CODE_WARN, 1'b0);
		load <= 3'h0;
		wt(3);
		for (int k = 0; k < 3; k++)
		begin
			load <= lv[k];
			wt(lim[k] - 10);
			warn(1'b1);
			wt(15);
			out(fault_pkg::CODE_TORQUE, 1'b1);
			load <= 3'h0;
			press();
		end
		wr(fault_pkg::REG_CTRL, 32'h1);
		wt(3);
		check("contact idle", {31'h0, fault_contact}, 32'h1);
		det <= 10'h1;
		wt(4);
		check("contact fault", {31'h0, fault_contact}, 32'h0);
		det <= 10'h0;
		press();
		wr(fault_pkg::REG_CTRL, 32'h0);
		dmg <= 1'b1;
		wt(2);
		dmg <= 1'b0;
		wt(3);
		press();
		check("damage", {30'h0, fault_contact, motor_stop}, 32'h3);
		rd(fault_pkg::REG_CODE, 32'h0002_2020);
		rd(fault_pkg::REG_STATUS, 32'h7);
		auto_mode <= 1'b1;
		machine_host_i.release_fault();
		wt(2);
		check("damage", {30'h0, fault_contact, motor_stop}, 32'h3);
		end_of_test();
	end
endmodule
